// [core/servo_shaping_pkg.sv]
package servo_shaping_pkg;
   // Clock and timing
   localparam int MCLK_MHZ = 40;
   localparam int CTRL_CYCLE_US = 166;
   localparam int CTRL_CYCLE_CYC = CTRL_CYCLE_US * MCLK_MHZ;
   localparam int CLEAR_MIN_US = 100;
   localparam int CLEAR_MIN_CYC = CLEAR_MIN_US * MCLK_MHZ;
   // Lag filter time constants in microseconds, index 0 is bypass
   localparam int LAG_TAU_US [8] = '{0, 200, 600, 1300, 2600, 5300, 10600, 21200};
   // Numeric limits
   localparam int GEAR_MAX = 10000;
   localparam int GEAR_EXP_MAX = 17;
   localparam int NUM_CAP_BASE = 4194304;
   localparam int SCALE_MIN = 10;
   localparam int SCALE_MAX = 2000;
   localparam int OFFSET_MAX = 2047;
   localparam int PRESET_MAX = 20000;
   localparam int ADC_PER_VOLT = 3333;
   localparam int LAG_FRAC = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_GEAR_NUM_ONE = 8'h00;
   localparam logic [7:0] OFS_GEAR_NUM_TWO = 8'h04;
   localparam logic [7:0] OFS_GEAR_EXP = 8'h08;
   localparam logic [7:0] OFS_GEAR_DEN = 8'h0C;
   localparam logic [7:0] OFS_LAG_SEL = 8'h10;
   localparam logic [7:0] OFS_FIR_SET = 8'h14;
   localparam logic [7:0] OFS_CLR_COND = 8'h18;
   localparam logic [7:0] OFS_PULSE_FMT = 8'h1C;
   localparam logic [7:0] OFS_SPD_SCALE = 8'h20;
   localparam logic [7:0] OFS_SPD_DIR = 8'h24;
   localparam logic [7:0] OFS_SPD_OFFSET = 8'h28;
   localparam logic [7:0] OFS_PRESET_ONE = 8'h2C;
   localparam logic [7:0] OFS_PRESET_TWO = 8'h30;
   localparam logic [7:0] OFS_PRESET_THREE = 8'h34;
   localparam logic [7:0] OFS_PRESET_FOUR = 8'h38;
   localparam logic [7:0] OFS_ZERO_DIR_SEL = 8'h3C;
   localparam logic [7:0] OFS_CONTROL = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h44;
   localparam logic [7:0] OFS_POS_TOTAL = 8'h48;
   // Reset values
   localparam logic [13:0] RST_GEAR_NUM = 14'h0000;
   localparam logic [4:0] RST_GEAR_EXP = 5'h00;
   localparam logic [13:0] RST_GEAR_DEN = 14'h2710;
   localparam logic [2:0] RST_LAG_SEL = 3'h0;
   localparam logic [4:0] RST_FIR_SET = 5'h00;
   localparam logic [1:0] RST_CLR_COND = 2'h1;
   localparam logic [1:0] RST_PULSE_FMT = 2'h1;
   localparam logic [10:0] RST_SPD_SCALE = 11'h12C;
   localparam logic RST_SPD_DIR = 1'b0;
   localparam logic [11:0] RST_SPD_OFFSET = 12'h000;
   localparam logic [15:0] RST_PRESET_ONE = 16'h0064;
   localparam logic [15:0] RST_PRESET_TWO = 16'h00C8;
   localparam logic [15:0] RST_PRESET_THREE = 16'h012C;
   localparam logic [15:0] RST_PRESET_FOUR = 16'h0032;
   localparam logic [1:0] RST_ZERO_DIR_SEL = 2'h0;
   // Clear modes, pulse formats, zero direction select and response codes
   localparam logic [1:0] CLR_LEVEL = 2'h0;
   localparam logic [1:0] CLR_EDGE = 2'h1;
   localparam logic [1:0] FMT_REV_FWD = 2'h1;
   localparam logic [1:0] FMT_FEED_DIR = 2'h3;
   localparam logic [1:0] ZSEL_NO_DIR = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/servo_command_shaping.sv]
`timescale 1ns/10ps
`default_nettype none
module servo_command_shaping
   import servo_shaping_pkg::*;
#(
   parameter int CTRL_BASE_CYC = CTRL_CYCLE_CYC,
   parameter int ENC_RES = 131072
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cmd_pulse_a,
   input wire logic cmd_pulse_b,
   input wire logic gear_numerator_select_n,
   input wire logic deviation_clear_input_n,
   input wire logic [11:0] speed_cmd_code,
   input wire logic speed_cmd_strobe,
   output logic [23:0] position_cmd_out,
   output logic position_cmd_valid,
   output logic deviation_clear,
   output logic [15:0] speed_cmd_rpm,
   output logic ctrl_tick
);
   // Clamp a signed value into a range
   function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input int lo, input int hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   logic [1:0] rst_sync_r;
   logic rst_n;
   logic [1:0] pa_sync_r, pb_sync_r, gsel_sync_r, clr_sync_r;
   logic pa_prev_r, pb_prev_r;
   logic [13:0] num_one_r, num_two_r, den_r;
   logic [4:0] exp_r, fir_r;
   logic [2:0] lag_sel_r;
   logic [1:0] clr_cond_r, pulse_fmt_r, zero_dir_sel_r;
   logic [10:0] scale_r;
   logic dir_r;
   logic [11:0] offset_r;
   logic [15:0] preset_r [4];
   logic [7:0] awaddr_r;
   logic aw_held_r, w_held_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [17:0] tick_cnt_r;
   logic tick;
   logic gsel_closed_r;
   logic signed [19:0] pulse_acc_r;
   logic signed [1:0] step;
   logic signed [47:0] gear_rem_r, lag_in_r, lag_q_r, lag_int_prev_r;
   logic signed [47:0] num_eff, den_eff, prod, gear_out, lag_err, lag_step, lag_in_nxt, lag_q_nxt;
   logic signed [47:0] lag_div, lag_inc;
   logic [31:0] num_scaled, num_cap;
   logic signed [23:0] fir_ring_r [32];
   logic [4:0] fir_wp_r;
   logic signed [31:0] fir_sum_r, fir_res_r, fir_tot, fir_n;
   logic signed [31:0] pos_total_r;
   logic [12:0] clr_cnt_r;
   logic clr_armed_r, clr_fired_r;
   logic wr_go;
   logic [31:0] rd_data;
   logic rd_hit;
   logic signed [31:0] spd_sum, spd_rpm;

   // Reset release through two flip-flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Pin synchronisers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pa_sync_r <= 2'h0;
         pb_sync_r <= 2'h0;
         gsel_sync_r <= 2'h3;
         clr_sync_r <= 2'h3;
         pa_prev_r <= 1'b0;
         pb_prev_r <= 1'b0;
      end else begin
         pa_sync_r <= {pa_sync_r[0], cmd_pulse_a};
         pb_sync_r <= {pb_sync_r[0], cmd_pulse_b};
         gsel_sync_r <= {gsel_sync_r[0], gear_numerator_select_n};
         clr_sync_r <= {clr_sync_r[0], deviation_clear_input_n};
         pa_prev_r <= pa_sync_r[1];
         pb_prev_r <= pb_sync_r[1];
      end
   end

   // Control cycle timer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= 18'h00000;
      end else if (tick) begin
         tick_cnt_r <= 18'h00000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 18'h00001;
      end
   end
   assign tick = (32'(tick_cnt_r) >= CTRL_BASE_CYC * (32'(fir_r) + 1) - 1);

   // Pulse decoding per format
   always_comb begin
      step = 2'sd0;
      unique case (pulse_fmt_r)
         FMT_REV_FWD: begin
            if (pb_sync_r[1] && !pb_prev_r) begin
               step = 2'sd1;
            end else if (pa_sync_r[1] && !pa_prev_r) begin
               step = -2'sd1;
            end
         end
         FMT_FEED_DIR: begin
            if (pa_sync_r[1] && !pa_prev_r) begin
               step = pb_sync_r[1] ? -2'sd1 : 2'sd1;
            end
         end
         default: begin
            if ((pa_sync_r[1] != pa_prev_r) || (pb_sync_r[1] != pb_prev_r)) begin
               step = ((pa_sync_r[1] ^ pb_prev_r) != 1'b0) ? 2'sd1 : -2'sd1;
               if ((pa_sync_r[1] != pa_prev_r) && (pb_sync_r[1] != pb_prev_r)) begin
                  step = 2'sd0;
               end
            end
         end
      endcase
   end

   // Pulse count per control cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_acc_r <= 20'sh00000;
      end else if (tick) begin
         pulse_acc_r <= 20'(step);
      end else begin
         pulse_acc_r <= pulse_acc_r + 20'(step);
      end
   end

   // Gear select sampled once per cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gsel_closed_r <= 1'b0;
      end else if (tick) begin
         gsel_closed_r <= !gsel_sync_r[1];
      end
   end

   // Electronic gear ratio
   always_comb begin
      num_scaled = (gsel_closed_r ? 32'(num_two_r) : 32'(num_one_r)) << exp_r;
      num_cap = 32'(NUM_CAP_BASE / (32'(fir_r) + 1));
      if (num_scaled == 32'h0) begin
         num_eff = 48'(ENC_RES);
      end else if (num_scaled > num_cap) begin
         num_eff = 48'(num_cap);
      end else begin
         num_eff = 48'(num_scaled);
      end
      den_eff = (den_r == 14'h0) ? 48'sd1 : 48'(den_r);
      prod = 48'(pulse_acc_r) * num_eff + gear_rem_r;
      gear_out = prod / den_eff;
   end

   // Lag filter on the commanded total
   always_comb begin
      lag_in_nxt = lag_in_r + gear_out;
      lag_div = 48'(LAG_TAU_US[lag_sel_r] / (CTRL_CYCLE_US * (32'(fir_r) + 1)));
      if (lag_div < 48'sd1) begin
         lag_div = 48'sd1;
      end
      lag_err = (lag_in_nxt <<< LAG_FRAC) - lag_q_r;
      lag_step = lag_err / lag_div;
      if ((lag_step == 48'sd0) && (lag_err != 48'sd0)) begin
         lag_step = (lag_err < 48'sd0) ? -48'sd1 : 48'sd1;
      end
      lag_q_nxt = (lag_sel_r == RST_LAG_SEL) ? (lag_in_nxt <<< LAG_FRAC) : lag_q_r + lag_step;
      lag_inc = (lag_q_nxt >>> LAG_FRAC) - lag_int_prev_r;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gear_rem_r <= 48'sh0;
         lag_in_r <= 48'sh0;
         lag_q_r <= 48'sh0;
         lag_int_prev_r <= 48'sh0;
      end else if (tick) begin
         gear_rem_r <= prod - gear_out * den_eff;
         lag_in_r <= lag_in_nxt;
         lag_q_r <= lag_q_nxt;
         lag_int_prev_r <= lag_q_nxt >>> LAG_FRAC;
      end
   end

   // FIR moving average over setting plus one cycles
   always_comb begin
      fir_n = 32'(fir_r) + 1;
      fir_tot = fir_sum_r + 32'(signed'(lag_inc[23:0])) - 32'(fir_ring_r[5'(fir_wp_r - 5'(fir_n))]) + fir_res_r;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fir_wp_r <= 5'h00;
         fir_sum_r <= 32'sh0;
         fir_res_r <= 32'sh0;
         for (int i = 0; i < 32; i++) begin
            fir_ring_r[i] <= 24'sh0;
         end
      end else if (tick) begin
         fir_ring_r[fir_wp_r] <= lag_inc[23:0];
         fir_wp_r <= fir_wp_r + 5'h01;
         fir_sum_r <= fir_tot - fir_res_r;
         fir_res_r <= fir_tot - (fir_tot / fir_n) * fir_n;
      end
   end

   // Shaped position output
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         position_cmd_out <= 24'h000000;
         position_cmd_valid <= 1'b0;
         pos_total_r <= 32'sh0;
         ctrl_tick <= 1'b0;
      end else begin
         position_cmd_valid <= tick;
         ctrl_tick <= tick;
         if (tick) begin
            position_cmd_out <= 24'(fir_tot / fir_n);
            pos_total_r <= pos_total_r + fir_tot / fir_n;
         end
      end
   end

   // Deviation clear qualification
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clr_cnt_r <= 13'h0000;
         clr_armed_r <= 1'b0;
         clr_fired_r <= 1'b0;
         deviation_clear <= 1'b0;
      end else begin
         deviation_clear <= 1'b0;
         if (clr_sync_r[1]) begin
            clr_cnt_r <= 13'h0000;
            clr_armed_r <= 1'b1;
            clr_fired_r <= 1'b0;
         end else if (32'(clr_cnt_r) < CLEAR_MIN_CYC) begin
            clr_cnt_r <= clr_cnt_r + 13'h0001;
         end else begin
            unique case (clr_cond_r)
               CLR_LEVEL: deviation_clear <= 1'b1;
               CLR_EDGE: begin
                  if (clr_armed_r && !clr_fired_r) begin
                     deviation_clear <= 1'b1;
                     clr_fired_r <= 1'b1;
                  end
               end
               default: deviation_clear <= 1'b0;
            endcase
         end
      end
   end

   // Speed command scaling
   always_comb begin
      spd_sum = 32'(signed'(speed_cmd_code)) + 32'(signed'(offset_r));
      spd_rpm = (spd_sum * signed'(32'(scale_r))) / ADC_PER_VOLT;
      if (dir_r && (zero_dir_sel_r != ZSEL_NO_DIR)) begin
         spd_rpm = -spd_rpm;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         speed_cmd_rpm <= 16'h0000;
      end else if (speed_cmd_strobe) begin
         speed_cmd_rpm <= 16'(spd_rpm);
      end
   end

   // AXI write channel capture
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r > OFS_CONTROL) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

   // Configuration registers, gear, scale, offset and preset fields range clamped on write
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         num_one_r <= RST_GEAR_NUM;
         num_two_r <= RST_GEAR_NUM;
         exp_r <= RST_GEAR_EXP;
         den_r <= RST_GEAR_DEN;
         lag_sel_r <= RST_LAG_SEL;
         fir_r <= RST_FIR_SET;
         clr_cond_r <= RST_CLR_COND;
         pulse_fmt_r <= RST_PULSE_FMT;
         scale_r <= RST_SPD_SCALE;
         dir_r <= RST_SPD_DIR;
         offset_r <= RST_SPD_OFFSET;
         zero_dir_sel_r <= RST_ZERO_DIR_SEL;
         preset_r[0] <= RST_PRESET_ONE;
         preset_r[1] <= RST_PRESET_TWO;
         preset_r[2] <= RST_PRESET_THREE;
         preset_r[3] <= RST_PRESET_FOUR;
      end else if (wr_go && wstrb_r[0]) begin
         unique case (awaddr_r)
            OFS_GEAR_NUM_ONE: num_one_r <= 14'(clamp(32'(wdata_r[15:0]), 0, GEAR_MAX));
            OFS_GEAR_NUM_TWO: num_two_r <= 14'(clamp(32'(wdata_r[15:0]), 0, GEAR_MAX));
            OFS_GEAR_EXP: exp_r <= 5'(clamp(32'(wdata_r[4:0]), 0, GEAR_EXP_MAX));
            OFS_GEAR_DEN: den_r <= 14'(clamp(32'(wdata_r[15:0]), 0, GEAR_MAX));
            OFS_LAG_SEL: lag_sel_r <= wdata_r[2:0];
            OFS_FIR_SET: fir_r <= wdata_r[4:0];
            OFS_CLR_COND: clr_cond_r <= wdata_r[1:0];
            OFS_PULSE_FMT: pulse_fmt_r <= wdata_r[1:0];
            OFS_SPD_SCALE: scale_r <= 11'(clamp(32'(wdata_r[15:0]), SCALE_MIN, SCALE_MAX));
            OFS_SPD_DIR: dir_r <= wdata_r[0];
            OFS_SPD_OFFSET: offset_r <= 12'(clamp(32'(signed'(wdata_r[15:0])), -OFFSET_MAX, OFFSET_MAX));
            OFS_PRESET_ONE, OFS_PRESET_TWO, OFS_PRESET_THREE, OFS_PRESET_FOUR:
               preset_r[2'((awaddr_r - OFS_PRESET_ONE) >> 2)] <=
                  16'(clamp(32'(signed'(wdata_r[15:0])), -PRESET_MAX, PRESET_MAX));
            OFS_ZERO_DIR_SEL: zero_dir_sel_r <= wdata_r[1:0];
            OFS_CONTROL: begin
               if (wdata_r[0]) begin
                  offset_r <= 12'(clamp(-32'(signed'(speed_cmd_code)), -OFFSET_MAX, OFFSET_MAX));
               end
            end
            default: ;
         endcase
      end
   end

   // Read decode
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         OFS_GEAR_NUM_ONE: rd_data = 32'(num_one_r);
         OFS_GEAR_NUM_TWO: rd_data = 32'(num_two_r);
         OFS_GEAR_EXP: rd_data = 32'(exp_r);
         OFS_GEAR_DEN: rd_data = 32'(den_r);
         OFS_LAG_SEL: rd_data = 32'(lag_sel_r);
         OFS_FIR_SET: rd_data = 32'(fir_r);
         OFS_CLR_COND: rd_data = 32'(clr_cond_r);
         OFS_PULSE_FMT: rd_data = 32'(pulse_fmt_r);
         OFS_SPD_SCALE: rd_data = 32'(scale_r);
         OFS_SPD_DIR: rd_data = 32'(dir_r);
         OFS_SPD_OFFSET: rd_data = 32'(signed'(offset_r));
         OFS_PRESET_ONE: rd_data = 32'(signed'(preset_r[0]));
         OFS_PRESET_TWO: rd_data = 32'(signed'(preset_r[1]));
         OFS_PRESET_THREE: rd_data = 32'(signed'(preset_r[2]));
         OFS_PRESET_FOUR: rd_data = 32'(signed'(preset_r[3]));
         OFS_ZERO_DIR_SEL: rd_data = 32'(zero_dir_sel_r);
         OFS_CONTROL: rd_data = 32'h0;
         OFS_STATUS: rd_data = {28'h0, clr_fired_r, !clr_sync_r[1], gsel_closed_r, ctrl_tick};
         OFS_POS_TOTAL: rd_data = pos_total_r;
         default: begin
            rd_data = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // AXI read channel
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [dv/servo_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module servo_host_model (
   input wire logic mclk,
   output logic pulse_a,
   output logic pulse_b,
   output logic sel_n,
   output logic clr_n
);
   initial pulse_a = 1'b0;
   initial pulse_b = 1'b0;
   initial sel_n = 1'b1;
   initial clr_n = 1'b1;
   // Pulse train, 40 cycles per level keeps the 1 us minimum width
   task automatic send(input logic [1:0] fmt, input logic rev, input int n);
      if (fmt == 2'h3) pulse_b <= rev;
      repeat (n) begin
         repeat (40) @(posedge mclk);
         if (fmt == 2'h3 || rev) pulse_a <= 1'b1;
         else pulse_b <= 1'b1;
         repeat (40) @(posedge mclk);
         if (fmt == 2'h3 || rev) pulse_a <= 1'b0;
         else pulse_b <= 1'b0;
      end
   endtask
   // Closed for n cycles, then open long enough to rearm the edge mode
   task automatic hold_clear(input int n);
      clr_n <= 1'b0;
      repeat (n) @(posedge mclk);
      clr_n <= 1'b1;
      repeat (100) @(posedge mclk);
   endtask
   task automatic select(input logic s);
      sel_n <= s;
   endtask
endmodule
`default_nettype wire

// [dv/servo_command_shaping_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module servo_command_shaping_monitor #(
   parameter int CTRL_BASE_CYC = 20
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic deviation_clear_input_n,
   input wire logic deviation_clear,
   input wire logic position_cmd_valid,
   input wire logic ctrl_tick
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   int gap_r;
   logic seen_r;
   // Cycles since the last control tick
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         gap_r <= 0;
         seen_r <= 1'b0;
      end else if (ctrl_tick) begin
         gap_r <= 0;
         seen_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 1;
      end
   end
   tick_spacing_a: assert property (ctrl_tick && seen_r |-> gap_r >= CTRL_BASE_CYC - 1)
      else $error("control ticks closer than one base cycle");
   tick_bound_a: assert property (ctrl_tick |-> ##[1:700] ctrl_tick)
      else $error("control tick missing");
   pos_follow_a: assert property (ctrl_tick |-> position_cmd_valid ##1 !position_cmd_valid)
      else $error("no position update after tick");
   clr_cause_a: assert property ($rose(deviation_clear) |-> $past(deviation_clear_input_n, 8) == 1'b0)
      else $error("clear without a closed input");
   clr_drop_a: assert property (deviation_clear_input_n [*8] |-> !deviation_clear)
      else $error("clear held with input open");
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response late");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read response dropped");
endmodule
bind servo_command_shaping servo_command_shaping_monitor #(.CTRL_BASE_CYC(CTRL_BASE_CYC)) mon (.mclk, .rstn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .deviation_clear_input_n, .deviation_clear, .position_cmd_valid,
   .ctrl_tick);
`default_nettype wire

// [dv/tb_servo_command_shaping.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_servo_command_shaping;
   import servo_shaping_pkg::*;
   logic mclk, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, speed_cmd_strobe = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [11:0] speed_cmd_code = 12'h000;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, position_cmd_valid;
   logic cmd_pulse_a, cmd_pulse_b, gear_numerator_select_n, deviation_clear_input_n, deviation_clear, ctrl_tick;
   logic [1:0] s_axi_bresp, s_axi_rresp, wresp;
   logic [15:0] speed_cmd_rpm;
   logic [23:0] position_cmd_out;
   int bad_count = 0, compares = 0, pos_sum = 0, clr_hits = 0;
   servo_command_shaping #(.CTRL_BASE_CYC(20), .ENC_RES(1024)) uut (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cmd_pulse_a, .cmd_pulse_b, .gear_numerator_select_n, .deviation_clear_input_n,
      .speed_cmd_code, .speed_cmd_strobe, .position_cmd_out, .position_cmd_valid, .deviation_clear,
      .speed_cmd_rpm, .ctrl_tick);
   servo_host_model host (.mclk, .pulse_a(cmd_pulse_a), .pulse_b(cmd_pulse_b),
      .sel_n(gear_numerator_select_n), .clr_n(deviation_clear_input_n));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Running totals of shaped position and clear cycles
   always @(posedge mclk) if (position_cmd_valid === 1'b1) pos_sum += $signed(position_cmd_out);
   always @(posedge mclk) if (deviation_clear === 1'b1) clr_hits++;
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid !== 1'b1) begin
         @(posedge mclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      wresp = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic t_defaults();
      logic [7:0] ofs [10] = '{OFS_LAG_SEL, OFS_FIR_SET, OFS_CLR_COND, OFS_SPD_SCALE, OFS_SPD_DIR,
         OFS_SPD_OFFSET, OFS_PRESET_ONE, OFS_PRESET_TWO, OFS_PRESET_THREE, OFS_PRESET_FOUR};
      logic [31:0] want [10] = '{32'h0, 32'h0, 32'h1, 32'h12C, 32'h0, 32'h0, 32'h64, 32'hC8, 32'h12C, 32'h32};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 10; i++) begin
         rd(ofs[i], d, r);
         chk("reset value", d, want[i]);
      end
      rd(8'h80, d, r);
      chk("unmapped response", {30'h0, r}, {30'h0, RESP_SLVERR});
      wr(8'h80, 32'h0);
      chk("write response", {30'h0, wresp}, {30'h0, RESP_SLVERR});
      $display("defaults test ended");
   endtask
   task automatic t_tick();
      int n;
      wr(OFS_FIR_SET, 32'h3);
      repeat (2) do @(posedge mclk); while (ctrl_tick !== 1'b1);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ctrl_tick !== 1'b1);
      chk("tick period", n, 80);
      wr(OFS_FIR_SET, 32'h0);
      $display("tick test ended");
   endtask
   task automatic gear(input int num, e, den, fmt, want, input logic sel, rev);
      wr(OFS_GEAR_NUM_ONE, sel ? num : 7);
      wr(OFS_GEAR_NUM_TWO, sel ? 7 : num);
      wr(OFS_GEAR_EXP, e);
      wr(OFS_GEAR_DEN, den);
      wr(OFS_PULSE_FMT, fmt);
      host.select(sel);
      repeat (60) @(posedge mclk);
      pos_sum = 0;
      host.send(fmt[1:0], rev, 5);
      repeat (80) @(posedge mclk);
      chk("position sum", pos_sum, want);
   endtask
   task automatic t_gear();
      gear(3, 0, 1, 1, 15, 1'b1, 1'b0);
      gear(3, 1, 2, 1, -15, 1'b0, 1'b1);
      gear(0, 0, 256, 1, 20, 1'b1, 1'b0);
      gear(64, 17, 4096, 1, 5120, 1'b1, 1'b0);
      gear(2, 0, 1, 3, -10, 1'b1, 1'b1);
      $display("gear test ended");
   endtask
   task automatic spd(input logic [11:0] code, input logic [15:0] want);
      @(posedge mclk);
      speed_cmd_code <= code;
      speed_cmd_strobe <= 1'b1;
      @(posedge mclk);
      speed_cmd_strobe <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("speed", {16'h0, speed_cmd_rpm}, {16'h0, want});
   endtask
   task automatic t_speed();
      logic [31:0] d;
      logic [1:0] r;
      spd(12'h457, 16'h0064);
      wr(OFS_SPD_DIR, 32'h1);
      spd(12'h457, 16'hFF9C);
      wr(OFS_ZERO_DIR_SEL, {30'h0, ZSEL_NO_DIR});
      spd(12'h457, 16'h0064);
      wr(OFS_SPD_OFFSET, 32'h457);
      spd(12'h005, 16'h0064);
      wr(OFS_CONTROL, 32'h1);
      rd(OFS_SPD_OFFSET, d, r);
      chk("auto offset", {20'h0, d[11:0]}, 32'hFFB);
      spd(12'h005, 16'h0000);
      spd(12'hBA9, 16'hFF9C);
      $display("speed test ended");
   endtask
   task automatic clr(input logic [1:0] mode, input int hold, lo, hi);
      wr(OFS_CLR_COND, {30'h0, mode});
      clr_hits = 0;
      host.hold_clear(hold);
      chk("clear count", 32'(clr_hits >= lo && clr_hits <= hi), 32'h1);
   endtask
   task automatic t_clear();
      clr(CLR_LEVEL, 4200, 150, 200);
      clr(CLR_LEVEL, 3000, 0, 0);
      clr(CLR_EDGE, 4200, 1, 1);
      clr(CLR_EDGE, 3000, 0, 0);
      clr(2'h2, 4200, 0, 0);
      $display("clear test ended");
   endtask
   task automatic conclude();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence after a five-cycle reset
   initial begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      repeat (6) @(posedge mclk);
      t_defaults();
      t_tick();
      t_gear();
      t_speed();
      t_clear();
      conclude();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge mclk);
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
